/* File: design/rea_regs.svh */
// register addresses, field positions, reset values and timing figures
`ifndef REA_REGS_SVH
`define REA_REGS_SVH

// addresses on the host register port
`define REA_ADDR_SR      8'h07
`define REA_ADDR_INT     8'h08
`define REA_ADDR_EV      8'h09
`define REA_ADDR_ATR     8'h0a
`define REA_ADDR_DTR     8'h0b
`define REA_ADDR_ALM0    8'h0c
`define REA_ADDR_ALM5    8'h11

// status register bits
`define REA_SR_FLAG_AUTO_CLEAR      7
`define REA_SR_EVT       3
`define REA_SR_ALM       2

// interrupt control bits
`define REA_INT_IM       7
`define REA_INT_ALARM_ON     6
`define REA_INT_FOBAT    4
`define REA_INT_FO_HI    3
`define REA_INT_FO_LO    0
`define REA_FO_OFF       4'h0
`define REA_FO_RAW       4'h1

// event config bits
`define REA_EV_PUOFF     7
`define REA_EV_BATOFF    6
`define REA_EV_HALT      5
`define REA_EV_EN        4
`define REA_EV_HYS_HI    3
`define REA_EV_HYS_LO    2
`define REA_EV_SMP_HI    1
`define REA_EV_SMP_LO    0

// trim fields, capacitance in half-pF units
`define REA_ATR_BM_HI    7
`define REA_ATR_BM_LO    6
`define REA_ATR_INV      5
`define REA_CAP_BASE     7'h12
`define REA_BM_D0        7'h00
`define REA_BM_D1        7'h7f
`define REA_BM_D2        7'h01
`define REA_BM_D3        7'h02
`define REA_DTR_SIGN     2
`define REA_DTR_B40      1
`define REA_DTR_B20      0
`define REA_PPM_HI       8'h28
`define REA_PPM_LO       8'h14

// alarm byte compare enable
`define REA_ALM_EN       7

// reset values
`define REA_RST_REG      8'h00
// load capacitance of the default trim code, in half-pF units
`define REA_RST_CAP      7'h32

// times in microseconds, clock in MHz
`define REA_CLK_MHZ      100
`define REA_HYS1_US      3900
`define REA_HYS2_US      15625
`define REA_HYS3_US      31250
`define REA_SMP1_US      500000
`define REA_SMP2_US      1000000
`define REA_SMP3_US      4000000
`define REA_PULSE_US     250000
`define REA_HYS1_CYC     (`REA_HYS1_US * `REA_CLK_MHZ)
`define REA_HYS2_CYC     (`REA_HYS2_US * `REA_CLK_MHZ)
`define REA_HYS3_CYC     (`REA_HYS3_US * `REA_CLK_MHZ)
`define REA_SMP1_CYC     (`REA_SMP1_US * `REA_CLK_MHZ)
`define REA_SMP2_CYC     (`REA_SMP2_US * `REA_CLK_MHZ)
`define REA_SMP3_CYC     (`REA_SMP3_US * `REA_CLK_MHZ)
`define REA_PULSE_CYC    (`REA_PULSE_US * `REA_CLK_MHZ)

`endif

/* File: design/rea_pkg.sv */
// shared types of the rtc event, alarm and trim block
package rea_pkg;
    typedef struct packed {
        logic [7:0] wday;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] sec;
    } rea_time_s;

    typedef struct packed {
        logic [6:0] cap_x1;
        logic [6:0] cap_x2;
        logic [7:0] ppm;
        logic       freq_trim_en;
    } rea_trim_s;

    typedef enum logic {FLT_IDLE, FLT_WIN} rea_flt_e;
endpackage

/* File: design/rea_evf.sv */
// event input sampler and bounce filter
`timescale 1ns/10ps
`default_nettype none
`include "rea_regs.svh"
module rea_evf #(
    parameter logic [31:0] SMP1_CYC = 32'(`REA_SMP1_CYC),
    parameter logic [31:0] SMP2_CYC = 32'(`REA_SMP2_CYC),
    parameter logic [31:0] SMP3_CYC = 32'(`REA_SMP3_CYC),
    parameter logic [31:0] HYS1_CYC = 32'(`REA_HYS1_CYC),
    parameter logic [31:0] HYS2_CYC = 32'(`REA_HYS2_CYC),
    parameter logic [31:0] HYS3_CYC = 32'(`REA_HYS3_CYC)
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // configuration
    input  wire logic       run,
    input  wire logic [1:0] sample_rate,
    input  wire logic [1:0] filter_time,
    // pin and result
    input  wire logic       event_input_pin,
    output logic            detect
);
    function automatic logic [31:0] pick(input logic [1:0] code, input logic [31:0] a,
                                         input logic [31:0] b, input logic [31:0] c);
        return (code == 2'h1) ? a : (code == 2'h2) ? b : (code == 2'h3) ? c : 32'h1;
    endfunction

    logic [31:0]       smp_cnt_ff;
    logic [31:0]       nxt_smp_cnt;
    logic [31:0]       win_cnt_ff;
    logic [31:0]       nxt_win_cnt;
    logic [31:0]       smp_len;
    logic [31:0]       win_len;
    logic              smp_tick;
    logic              filtered;
    rea_pkg::rea_flt_e state_ff;
    rea_pkg::rea_flt_e nxt_state;

    assign smp_len     = pick(sample_rate, SMP1_CYC, SMP2_CYC, SMP3_CYC);
    assign win_len     = pick(filter_time, HYS1_CYC, HYS2_CYC, HYS3_CYC);
    assign smp_tick    = (sample_rate == 2'h0) || (smp_cnt_ff >= smp_len - 32'h1);
    assign filtered    = (sample_rate != 2'h0) && (filter_time != 2'h0);
    assign nxt_smp_cnt = (!run || smp_tick) ? 32'h0 : smp_cnt_ff + 32'h1;

    always_comb begin
        nxt_state   = state_ff;
        nxt_win_cnt = 32'h0;
        detect      = 1'b0;
        unique case (state_ff)
            rea_pkg::FLT_IDLE: begin
                if (run && smp_tick && event_input_pin) begin
                    if (filtered) begin
                        nxt_state = rea_pkg::FLT_WIN;
                    end else begin
                        detect = 1'b1;
                    end
                end
            end
            rea_pkg::FLT_WIN: begin
                if (!run || !event_input_pin) begin
                    nxt_state = rea_pkg::FLT_IDLE;
                end else if (win_cnt_ff >= win_len - 32'h1) begin
                    detect    = 1'b1;
                    nxt_state = rea_pkg::FLT_IDLE;
                end else begin
                    nxt_win_cnt = win_cnt_ff + 32'h1;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            smp_cnt_ff <= 32'h0;
            win_cnt_ff <= 32'h0;
            state_ff   <= rea_pkg::FLT_IDLE;
        end else begin
            smp_cnt_ff <= nxt_smp_cnt;
            win_cnt_ff <= nxt_win_cnt;
            state_ff   <= nxt_state;
        end
    end

    default clocking dflt_cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence win_open_s;
        state_ff == rea_pkg::FLT_IDLE && run && smp_tick && event_input_pin && filtered;
    endsequence
    sequence win_drop_s;
        state_ff == rea_pkg::FLT_WIN && !event_input_pin;
    endsequence

    win_open_a: assert property (win_open_s |-> !detect ##1 state_ff == rea_pkg::FLT_WIN)
        else $error("filtered event detected without waiting");
    bounce_drop_a: assert property (win_drop_s |-> !detect ##1 state_ff == rea_pkg::FLT_IDLE)
        else $error("short event pulse was not discarded");
    direct_hit_a: assert property ((run && !filtered && smp_tick && event_input_pin
        && state_ff == rea_pkg::FLT_IDLE) |-> detect)
        else $error("unfiltered sample did not detect");
endmodule
`default_nettype wire

/* File: design/rea_top.sv */
// event detect configuration, alarm compare and oscillator trim of the rtc
`timescale 1ns/10ps
`default_nettype none
`include "rea_regs.svh"
module rea_top #(
    parameter logic [31:0] SMP1_CYC  = 32'(`REA_SMP1_CYC),
    parameter logic [31:0] SMP2_CYC  = 32'(`REA_SMP2_CYC),
    parameter logic [31:0] SMP3_CYC  = 32'(`REA_SMP3_CYC),
    parameter logic [31:0] HYS1_CYC  = 32'(`REA_HYS1_CYC),
    parameter logic [31:0] HYS2_CYC  = 32'(`REA_HYS2_CYC),
    parameter logic [31:0] HYS3_CYC  = 32'(`REA_HYS3_CYC),
    parameter logic [31:0] PULSE_CYC = 32'(`REA_PULSE_CYC)
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               nrst,
    // host register port
    input  wire logic               reg_wr,
    input  wire logic               reg_rd_done,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    output logic [7:0]              reg_rdata,
    // time counter side
    input  wire rea_pkg::rea_time_s time_now,
    input  wire logic               time_tick,
    input  wire logic               time_write_done,
    input  wire logic               battery_mode,
    output logic                    rtc_halt,
    // event pins
    input  wire logic               event_input_pin,
    output logic                    event_output_n_o,
    output logic                    event_output_n_oe,
    output logic                    event_pullup_off,
    // alarm pin
    output logic                    irq_n_o,
    output logic                    irq_n_oe,
    output logic [3:0]              freq_output,
    // oscillator trim
    output rea_pkg::rea_trim_s      trim
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    logic [7:0]         int_ff;
    logic [7:0]         ev_ff;
    logic [7:0]         atr_ff;
    logic [2:0]         dtr_ff;
    logic [7:0]         alm_ff [6];
    logic               flag_auto_clear_ff;
    logic               alarm_flag_ff;
    logic               event_flag_ff;
    logic               halt_ff;
    logic [31:0]        pulse_cnt_ff;
    logic [7:0]         rdata_ff;
    logic               pullup_off_ff;
    rea_pkg::rea_trim_s trim_ff;
    logic               nxt_alarm_flag;
    logic               nxt_event_flag;
    logic               nxt_halt;
    logic [31:0]        nxt_pulse_cnt;
    rea_pkg::rea_trim_s nxt_trim;
    logic [5:0][7:0]    time_fld;
    logic [5:0]         fld_hit;
    logic [5:0]         fld_en;
    logic               wr_sr;
    logic               wr_int;
    logic               wr_ev;
    logic               wr_atr;
    logic               wr_dtr;
    logic               rd_sr;
    logic               in_alm;
    logic [2:0]         alm_idx;
    logic [7:0]         sr_view;
    logic [7:0]         rd_mux;
    logic               detect;
    logic               ev_en;
    logic               halt_set;
    logic               resume;
    logic               alarm_live;
    logic               pulse_mode;
    logic               alarm_match;
    logic               alarm_clr;
    logic               event_clr;
    logic               pin_off;
    logic [6:0]         bm_delta;
    logic [6:0]         cap_half;
    logic [7:0]         ppm_mag;

    // address decode
    assign wr_sr   = reg_wr && hit(reg_addr, `REA_ADDR_SR);
    assign wr_int  = reg_wr && hit(reg_addr, `REA_ADDR_INT);
    assign wr_ev   = reg_wr && hit(reg_addr, `REA_ADDR_EV);
    assign wr_atr  = reg_wr && hit(reg_addr, `REA_ADDR_ATR);
    assign wr_dtr  = reg_wr && hit(reg_addr, `REA_ADDR_DTR);
    assign rd_sr   = reg_rd_done && hit(reg_addr, `REA_ADDR_SR);
    assign in_alm  = (reg_addr >= `REA_ADDR_ALM0) && (reg_addr <= `REA_ADDR_ALM5);
    assign alm_idx = 3'(reg_addr - `REA_ADDR_ALM0);

    // read selection
    assign sr_view = (8'(flag_auto_clear_ff) << `REA_SR_FLAG_AUTO_CLEAR) | (8'(event_flag_ff) << `REA_SR_EVT)
                   | (8'(alarm_flag_ff) << `REA_SR_ALM);
    assign rd_mux  = hit(reg_addr, `REA_ADDR_SR)  ? sr_view :
                     hit(reg_addr, `REA_ADDR_INT) ? int_ff :
                     hit(reg_addr, `REA_ADDR_EV)  ? ev_ff :
                     hit(reg_addr, `REA_ADDR_ATR) ? atr_ff :
                     hit(reg_addr, `REA_ADDR_DTR) ? {5'h00, dtr_ff} :
                     in_alm                       ? alm_ff[alm_idx] : `REA_RST_REG;

    // event detection
    assign ev_en    = ev_ff[`REA_EV_EN];
    assign halt_set = detect && ev_en && ev_ff[`REA_EV_HALT];
    assign resume   = halt_ff && time_write_done;
    assign nxt_halt = halt_set || (halt_ff && !time_write_done);
    assign event_clr      = wr_sr && !reg_wdata[`REA_SR_EVT];
    assign nxt_event_flag = detect || (event_flag_ff && !event_clr);

    rea_evf #(
        .SMP1_CYC (SMP1_CYC),
        .SMP2_CYC (SMP2_CYC),
        .SMP3_CYC (SMP3_CYC),
        .HYS1_CYC (HYS1_CYC),
        .HYS2_CYC (HYS2_CYC),
        .HYS3_CYC (HYS3_CYC)
    ) u_evf (
        .core_clk        (core_clk),
        .nrst            (nrst),
        .run             (ev_en),
        .sample_rate     (ev_ff[`REA_EV_SMP_HI:`REA_EV_SMP_LO]),
        .filter_time     (ev_ff[`REA_EV_HYS_HI:`REA_EV_HYS_LO]),
        .event_input_pin (event_input_pin),
        .detect          (detect)
    );

    // alarm compare
    assign time_fld = time_now;
    for (genvar i = 0; i < 6; i++) begin : g_alm
        localparam logic [7:0] ADDR = `REA_ADDR_ALM0 + 8'(i);
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                alm_ff[i] <= `REA_RST_REG;
            end else if (reg_wr && hit(reg_addr, ADDR)) begin
                alm_ff[i] <= reg_wdata;
            end
        end
        assign fld_en[i]  = alm_ff[i][`REA_ALM_EN];
        assign fld_hit[i] = !fld_en[i] || (alm_ff[i][6:0] == time_fld[i][6:0]);
    end

    assign freq_output = int_ff[`REA_INT_FO_HI:`REA_INT_FO_LO];
    assign pulse_mode  = int_ff[`REA_INT_IM];
    assign alarm_live  = int_ff[`REA_INT_ALARM_ON] && (freq_output == `REA_FO_OFF);
    assign alarm_match = time_tick && !halt_ff && alarm_live && (|fld_en) && (&fld_hit);
    assign alarm_clr   = (wr_sr && !reg_wdata[`REA_SR_ALM]) || (rd_sr && flag_auto_clear_ff);
    assign nxt_alarm_flag = alarm_match || (alarm_flag_ff && !alarm_clr);
    assign nxt_pulse_cnt  = (alarm_match && pulse_mode) ? PULSE_CYC :
                            (pulse_cnt_ff != 32'h0) ? pulse_cnt_ff - 32'h1 : 32'h0;

    // pin drive
    assign pin_off           = battery_mode && int_ff[`REA_INT_FOBAT];
    assign irq_n_o           = 1'b0;
    assign irq_n_oe          = alarm_live && !pin_off
                             && (pulse_mode ? (pulse_cnt_ff != 32'h0) : alarm_flag_ff);
    assign event_output_n_o  = 1'b0;
    assign event_output_n_oe = event_flag_ff && !(battery_mode && ev_ff[`REA_EV_BATOFF]);
    assign event_pullup_off  = pullup_off_ff;
    assign rtc_halt          = halt_ff;
    assign reg_rdata         = rdata_ff;
    assign trim              = trim_ff;

    // trim values
    assign bm_delta = !battery_mode ? `REA_BM_D0 :
                      (atr_ff[`REA_ATR_BM_HI:`REA_ATR_BM_LO] == 2'h1) ? `REA_BM_D1 :
                      (atr_ff[`REA_ATR_BM_HI:`REA_ATR_BM_LO] == 2'h2) ? `REA_BM_D2 :
                      (atr_ff[`REA_ATR_BM_HI:`REA_ATR_BM_LO] == 2'h3) ? `REA_BM_D3 : `REA_BM_D0;
    assign cap_half = `REA_CAP_BASE + {1'b0, !atr_ff[`REA_ATR_INV], atr_ff[4:0]} + bm_delta;
    assign ppm_mag  = (dtr_ff[`REA_DTR_B40] ? `REA_PPM_HI : 8'h00)
                    + (dtr_ff[`REA_DTR_B20] ? `REA_PPM_LO : 8'h00);
    assign nxt_trim.cap_x1       = cap_half;
    assign nxt_trim.cap_x2       = cap_half;
    assign nxt_trim.ppm          = dtr_ff[`REA_DTR_SIGN] ? 8'h00 - ppm_mag : ppm_mag;
    assign nxt_trim.freq_trim_en = (freq_output != `REA_FO_OFF) && (freq_output != `REA_FO_RAW);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            int_ff <= `REA_RST_REG;
            atr_ff <= `REA_RST_REG;
            dtr_ff <= 3'h0;
            flag_auto_clear_ff <= 1'b0;
        end else begin
            if (wr_int) int_ff <= reg_wdata;
            if (wr_atr) atr_ff <= reg_wdata;
            if (wr_dtr) dtr_ff <= reg_wdata[2:0];
            if (wr_sr) flag_auto_clear_ff <= reg_wdata[`REA_SR_FLAG_AUTO_CLEAR];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ev_ff <= `REA_RST_REG;
        end else if (wr_ev) begin
            ev_ff <= reg_wdata;
        end else if (resume) begin
            ev_ff[`REA_EV_HALT] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            alarm_flag_ff <= 1'b0;
            event_flag_ff <= 1'b0;
            halt_ff       <= 1'b0;
            pulse_cnt_ff  <= 32'h0;
            rdata_ff      <= `REA_RST_REG;
            pullup_off_ff <= 1'b0;
            trim_ff       <= '{cap_x1:       `REA_RST_CAP,
                               cap_x2:       `REA_RST_CAP,
                               ppm:          8'h00,
                               freq_trim_en: 1'b0};
        end else begin
            alarm_flag_ff <= nxt_alarm_flag;
            event_flag_ff <= nxt_event_flag;
            halt_ff       <= nxt_halt;
            pulse_cnt_ff  <= nxt_pulse_cnt;
            rdata_ff      <= rd_mux;
            pullup_off_ff <= ev_ff[`REA_EV_PUOFF];
            trim_ff       <= nxt_trim;
        end
    end

    default clocking dflt_cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence halt_cause_s;
        detect && ev_ff[`REA_EV_EN] && ev_ff[`REA_EV_HALT];
    endsequence
    sequence resume_s;
        halt_ff && time_write_done && !detect && !wr_ev;
    endsequence

    pullup_ctl_a: assert property (wr_ev |=> ##1 event_pullup_off == $past(reg_wdata[7], 2))
        else $error("pullup control does not follow config");
    detect_off_a: assert property ((!ev_en && !event_flag_ff) |=> !event_flag_ff)
        else $error("event flagged while detection disabled");
    halt_set_a: assert property (halt_cause_s |=> rtc_halt)
        else $error("event did not halt the counters");
    halt_needs_en_a: assert property ((!ev_en && !halt_ff) |=> !rtc_halt)
        else $error("counters halted with detection disabled");
    halt_resume_a: assert property (resume_s |=> !rtc_halt && !ev_ff[`REA_EV_HALT])
        else $error("time write did not resume counting");
    halt_hold_a: assert property ((halt_ff && !time_write_done) |=> rtc_halt)
        else $error("halt released without a time write");
    evout_batt_a: assert property ((battery_mode && ev_ff[`REA_EV_BATOFF]) |-> !event_output_n_oe)
        else $error("event output driven in battery mode");
    alarm_set_a: assert property (alarm_match |=> alarm_flag_ff)
        else $error("alarm match did not set the flag");
    single_irq_a: assert property ((alarm_live && !pulse_mode && alarm_flag_ff && !pin_off)
        |-> irq_n_oe)
        else $error("single alarm irq not held low");
    pulse_start_a: assert property ((alarm_match && pulse_mode) |=> pulse_cnt_ff == PULSE_CYC)
        else $error("alarm pulse length wrong");
    auto_clear_a: assert property ((rd_sr && flag_auto_clear_ff && !alarm_match) |=> !alarm_flag_ff)
        else $error("status read did not auto clear alarm");
    dtr_sign_a: assert property ((wr_dtr && reg_wdata[2:0] == 3'h7) |=> ##1 trim.ppm == 8'hc4)
        else $error("digital trim value wrong");
    pulse_end_a: assert property ((pulse_cnt_ff == 32'h1 && !alarm_match) |=> pulse_cnt_ff == 32'h0)
        else $error("alarm pulse did not end");
    pulse_irq_a: assert property ((alarm_live && pulse_mode && !pin_off && pulse_cnt_ff != 32'h0)
        |-> irq_n_oe)
        else $error("alarm pulse not driven on irq");
    raw_no_trim_a: assert property ((freq_output == `REA_FO_RAW) |=> !trim.freq_trim_en)
        else $error("digital trim applied to raw frequency");
    evout_on_a: assert property ((event_flag_ff && !battery_mode) |-> event_output_n_oe)
        else $error("event output not asserted with flag set");
endmodule
`default_nettype wire

/* File: tb/rea_host.sv */
// host model that reaches the rtc registers one byte at a time
`timescale 1ns/10ps
`default_nettype none
module rea_host (
    // clock
    input  wire logic       core_clk,
    // register port
    output logic            reg_wr,
    output logic            reg_rd_done,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd_done = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // byte write, strobe held for one cycle, data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // byte read closed by a done pulse, as after a stop on the serial bus
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        @(posedge core_clk);
        #1;
        d = reg_rdata;
        reg_rd_done = 1'b1;
        @(posedge core_clk);
        #1;
        reg_rd_done = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: tb/test_rtc_event_alarm_trim.sv */
// self-checking testbench of the rtc event, alarm and trim block
`timescale 1ns/10ps
`default_nettype none
module test_rtc_event_alarm_trim;
    logic               core_clk;
    logic               nrst;
    logic               reg_wr;
    logic               reg_rd_done;
    logic [7:0]         reg_addr;
    logic [7:0]         reg_wdata;
    logic [7:0]         reg_rdata;
    rea_pkg::rea_time_s time_now;
    logic               time_tick;
    logic               time_write_done;
    logic               battery_mode;
    logic               rtc_halt;
    logic               event_input_pin;
    logic               event_output_n_oe;
    logic               event_pullup_off;
    logic               irq_n_oe;
    logic               event_output_n_o;
    logic               irq_n_o;
    logic [3:0]         freq_output;
    rea_pkg::rea_trim_s trim;
    logic [7:0]         v;
    int                 errors;
    int                 samples_checked;

    rea_top #(.SMP1_CYC(32'h28), .HYS1_CYC(32'h4), .HYS2_CYC(32'h8), .HYS3_CYC(32'hc),
              .PULSE_CYC(32'ha)) DUT (
        .core_clk, .nrst, .reg_wr, .reg_rd_done, .reg_addr, .reg_wdata, .reg_rdata,
        .time_now, .time_tick, .time_write_done, .battery_mode, .rtc_halt,
        .event_input_pin, .event_output_n_o, .event_output_n_oe, .event_pullup_off,
        .irq_n_o, .irq_n_oe, .freq_output, .trim
    );
    rea_host host (.core_clk, .reg_wr, .reg_rd_done, .reg_addr, .reg_wdata, .reg_rdata);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #500000;
        errors++;
        results();
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic tick(input logic [7:0] s);
        time_now.sec = s;
        time_tick = 1'b1;
        step(1);
        time_tick = 1'b0;
    endtask
    task automatic t_reset();
        chk(trim.cap_x1, 8'h32);
        chk(trim.ppm, 8'h00);
        host.rd(8'h09, v);
        chk(v, 8'h00);
    endtask
    task automatic t_trim();
        logic [7:0] analog_trim[5] = '{8'h00, 8'h20, 8'h1f, 8'hdf, 8'h5f};
        logic [7:0] cap[5] = '{8'h32, 8'h12, 8'h51, 8'h53, 8'h50};
        logic [7:0] ppm[8] = '{8'h00, 8'h14, 8'h28, 8'h3c, 8'h00, 8'hec, 8'hd8, 8'hc4};
        battery_mode = 1'b1;
        for (int i = 0; i < 5; i++) begin
            host.wr(8'h0a, analog_trim[i]);
            step(2);
            chk(trim.cap_x1, cap[i]);
            chk(trim.cap_x2, cap[i]);
        end
        battery_mode = 1'b0;
        step(2);
        chk(trim.cap_x1, 8'h51);
        for (int i = 0; i < 8; i++) begin
            host.wr(8'h0b, 8'(i));
            step(2);
            chk(trim.ppm, ppm[i]);
        end
        host.wr(8'h08, 8'h02);
        step(2);
        chk(trim.freq_trim_en, 1'b1);
        chk(freq_output, 4'h2);
        host.wr(8'h08, 8'h01);
        step(2);
        chk(trim.freq_trim_en, 1'b0);
    endtask
    task automatic t_event();
        event_input_pin = 1'b1;
        host.wr(8'h09, 8'ha0);
        step(4);
        chk(event_pullup_off, 1'b1);
        chk(rtc_halt, 1'b0);
        chk(event_output_n_oe, 1'b0);
        host.wr(8'h09, 8'h30);
        step(4);
        chk(event_pullup_off, 1'b0);
        chk(rtc_halt, 1'b1);
        chk(event_output_n_oe, 1'b1);
        chk(event_output_n_o, 1'b0);
        host.rd(8'h07, v);
        chk(v, 8'h08);
        battery_mode = 1'b1;
        host.wr(8'h09, 8'h70);
        step(2);
        chk(event_output_n_oe, 1'b0);
        host.wr(8'h09, 8'h30);
        step(2);
        chk(event_output_n_oe, 1'b1);
        battery_mode = 1'b0;
        event_input_pin = 1'b0;
        step(5);
        chk(rtc_halt, 1'b1);
        time_write_done = 1'b1;
        step(1);
        time_write_done = 1'b0;
        step(1);
        chk(rtc_halt, 1'b0);
        host.rd(8'h09, v);
        chk(v, 8'h10);
        host.wr(8'h07, 8'h00);
    endtask
    task automatic t_filter();
        int hys[3] = '{4, 8, 12};
        for (int i = 0; i < 3; i++) begin
            host.wr(8'h09, 8'h15 + 8'(i) * 8'h04);
            repeat (20) begin
                event_input_pin = 1'b1;
                step(hys[i] - 1);
                event_input_pin = 1'b0;
                step(1);
            end
            host.rd(8'h07, v);
            chk(v, 8'h00);
            event_input_pin = 1'b1;
            step(60);
            event_input_pin = 1'b0;
            host.rd(8'h07, v);
            chk(v, 8'h08);
            host.wr(8'h07, 8'h00);
        end
        host.wr(8'h09, 8'h12);
        event_input_pin = 1'b1;
        step(60);
        event_input_pin = 1'b0;
        host.rd(8'h07, v);
        chk(v, 8'h00);
        host.wr(8'h09, 8'h1c);
        event_input_pin = 1'b1;
        step(2);
        event_input_pin = 1'b0;
        host.rd(8'h07, v);
        chk(v, 8'h08);
        host.wr(8'h07, 8'h00);
    endtask
    task automatic t_alarm();
        host.wr(8'h0c, 8'h85);
        host.wr(8'h08, 8'h00);
        tick(8'h05);
        step(2);
        chk(irq_n_oe, 1'b0);
        host.wr(8'h08, 8'h41);
        tick(8'h05);
        step(2);
        chk(irq_n_oe, 1'b0);
        host.wr(8'h08, 8'h40);
        tick(8'h04);
        host.wr(8'h0d, 8'h81);
        tick(8'h05);
        host.rd(8'h07, v);
        chk(v, 8'h00);
        time_now.minute = 8'h01;
        tick(8'h05);
        step(3);
        chk(irq_n_oe, 1'b1);
        chk(irq_n_o, 1'b0);
        host.rd(8'h07, v);
        chk(v, 8'h04);
        host.wr(8'h07, 8'h00);
        step(1);
        chk(irq_n_oe, 1'b0);
        host.wr(8'h07, 8'h80);
        tick(8'h05);
        host.rd(8'h07, v);
        chk(v, 8'h84);
        host.rd(8'h07, v);
        chk(v, 8'h80);
    endtask
    task automatic t_pulse();
        int n;
        host.wr(8'h07, 8'h00);
        host.wr(8'h08, 8'hc0);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            tick(8'h05);
            repeat (30) begin
                n += int'(irq_n_oe === 1'b1);
                step(1);
            end
            chk(8'(n), 8'h0a);
        end
        host.rd(8'h07, v);
        chk(v, 8'h04);
    endtask
    initial begin
        nrst = 1'b0;
        time_now = '0;
        time_tick = 1'b0;
        time_write_done = 1'b0;
        battery_mode = 1'b0;
        event_input_pin = 1'b0;
        errors = 0;
        samples_checked = 0;
        repeat (6) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        t_reset();
        t_trim();
        t_event();
        t_filter();
        t_alarm();
        t_pulse();
        results();
    end
endmodule
`default_nettype wire
